// ---- core/rssl_top.sv ----
// module: reset sequencer, flash security latch and jtag lockout recovery with an AHB-Lite slave
// Operation
// - four reset sources: pin, power-on, software, watchdog
// - power-on extended, then 32-cycle clock start
// - 32-cycle peripheral window, then 32-cycle core
// - release of reset always on clock edge
// - security from two nonvolatile security bytes
// - secure state disables enhanced debug port
// - boot selects unsecured or secure mode
// - jtag port always active with identification
// - debug memory reads blocked per security bytes
// - recovery erases flash, clearing security
// - recovery instruction selects 7-bit divider register
// - divider bit 6 prescale, bits 5:0 ratio
// - erase starts entering run-test/idle, host holds
// - backdoor unsecure only when key allowed
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rssl_top #(
    parameter int unsigned POR_EXT_CYCLES = rssl_pkg::POR_EXT_DEFAULT
) (
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    input  wire logic                        EXT_RESET_N,
    input  wire logic                        POR_N,
    input  wire logic                        WDOG_RESET,
    input  wire logic [7:0]                  SEC_BYTE_LO,
    input  wire logic [7:0]                  SEC_BYTE_HI,
    input  wire logic [31:0]                 BACKDOOR_KEY,
    input  wire logic                        FLASH_ERASE_DONE,
    output logic                             CLK_ENABLE,
    output logic                             PERIPH_RESET,
    output logic                             CORE_RESET,
    output logic                             DEBUG_PORT_EN,
    output logic                             DEBUG_READ_BLOCK,
    output logic                             FLASH_ERASE_REQ,
    output logic                             FLASH_PRESCALE_BY_EIGHT,
    output logic [5:0]                       FLASH_CLOCK_RATIO,
    input  wire logic                        TCK,
    input  wire logic                        TMS,
    input  wire logic                        TDI,
    input  wire logic                        TRST_N,
    output logic                             TDO,
    output logic                             TDO_OE_N,
    input  wire logic                        HSEL,
    input  wire logic [31:0]                 HADDR,
    input  wire logic [1:0]                  HTRANS,
    input  wire logic                        HWRITE,
    input  wire logic [2:0]                  HSIZE,
    input  wire logic [31:0]                 HWDATA,
    input  wire logic                        HREADY,
    output logic                             HREADYOUT,
    output logic                             HRESP,
    output logic [31:0]                      HRDATA
);
    import rssl_pkg::*;

    localparam int unsigned SYNC_W = 6;
    localparam int unsigned SY_EXT = 0;
    localparam int unsigned SY_POR = 1;
    localparam int unsigned SY_TCK = 2;
    localparam int unsigned SY_TMS = 3;
    localparam int unsigned SY_TDI = 4;
    localparam int unsigned SY_TRN = 5;
    localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_EXT_CYCLES - 1);
    localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WINDOW_CYCLES - 1);

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic              tck_prev;
        rssl_seq_e         seq;
        logic [CNT_W-1:0]  cnt;
        logic              in_reset;
        logic              por_pending;
        logic              clk_run;
        logic              periph_hold;
        logic              core_hold;
        logic              secure;
        logic              key_allow;
        logic              erase_busy;
        logic              erase_done;
        logic              idle_prev;
        logic [DIV_W-1:0]  clkdiv;
        logic [DIV_W-1:0]  div_out;
        logic              sw_reset;
        logic              dp_write;
        logic [ADDR_W-1:0] dp_addr;
        logic [31:0]       rdata;
    } rssl_top_s;

    rssl_top_s s_q, s_d;
    rssl_tap_if tif ();

    logic        any_src;
    logic        addr_ok;
    logic [31:0] status_word;

    rssl_tap u_tap (
        .clk   (CLK),
        .reset (RESET),
        .tif   (tif.tap)
    );

    // jtag pins reach the port only through the second sync stage
    assign tif.tck_rise = s_q.sync2[SY_TCK] && !s_q.tck_prev;
    assign tif.tms      = s_q.sync2[SY_TMS];
    assign tif.tdi      = s_q.sync2[SY_TDI];
    assign tif.trst     = !s_q.sync2[SY_TRN];

    always_comb begin
        status_word = '0;
        status_word[ST_SEQ_LSB +: 3] = s_q.seq;
        status_word[ST_SECURE]       = s_q.secure;
        status_word[ST_KEY_ALLOW]    = s_q.key_allow;
        status_word[ST_ERASE_BSY]    = s_q.erase_busy;
        status_word[ST_ERASE_DON]    = s_q.erase_done;
        status_word[ST_DIV_VALID]    = tif.div_valid;
    end

    assign any_src = !s_q.sync2[SY_EXT] || !s_q.sync2[SY_POR] || WDOG_RESET || s_q.sw_reset;
    assign addr_ok = (HSIZE == 3'h2) && (HADDR[1:0] == 2'h0);

    always_comb begin
        s_d = s_q;
        s_d.sync1    = {TRST_N, TDI, TMS, TCK, POR_N, EXT_RESET_N};
        s_d.sync2    = s_q.sync1;
        s_d.tck_prev = s_q.sync2[SY_TCK];
        s_d.sw_reset = 1'b0;
        s_d.idle_prev = tif.run_idle;

        // reset sequencing
        if (any_src) begin
            s_d.in_reset    = 1'b1;
            s_d.cnt         = '0;
            s_d.clk_run     = 1'b0;
            s_d.periph_hold = 1'b1;
            s_d.core_hold   = 1'b1;
            s_d.seq         = SEQ_POR_EXT;
            if (!s_q.sync2[SY_POR]) begin
                s_d.por_pending = 1'b1;
            end
        end else if (s_q.in_reset) begin
            s_d.in_reset    = 1'b0;
            s_d.cnt         = '0;
            s_d.por_pending = 1'b0;
            s_d.seq         = s_q.por_pending ? SEQ_POR_EXT : SEQ_CLK_START;
            s_d.clk_run     = !s_q.por_pending;
        end else begin
            s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
            case (s_q.seq)
                SEQ_POR_EXT: begin
                    if (s_q.cnt == POR_LAST) begin
                        s_d.cnt     = '0;
                        s_d.seq     = SEQ_CLK_START;
                        s_d.clk_run = 1'b1;
                    end
                end
                SEQ_CLK_START: begin
                    if (s_q.cnt == WIN_LAST) begin
                        s_d.cnt         = '0;
                        s_d.seq         = SEQ_PERIPH;
                        s_d.periph_hold = 1'b0;
                        // secured state chosen from the security bytes at boot
                        s_d.secure    = (SEC_BYTE_LO[1:0] != SEC_UNSECURE_CODE);
                        s_d.key_allow = (SEC_BYTE_HI[KEY_ALLOW_LSB +: 2] == KEY_ALLOW_CODE);
                    end
                end
                SEQ_PERIPH: begin
                    if (s_q.cnt == WIN_LAST) begin
                        s_d.cnt = '0;
                        s_d.seq = SEQ_CORE;
                    end
                end
                SEQ_CORE: begin
                    if (s_q.cnt == WIN_LAST) begin
                        s_d.cnt       = '0;
                        s_d.seq       = SEQ_RUN;
                        s_d.core_hold = 1'b0;
                    end
                end
                SEQ_RUN: begin
                    s_d.cnt = '0;
                end
                default: begin
                    s_d.seq = SEQ_POR_EXT;
                end
            endcase
        end

        // lockout recovery erase
        if (!s_q.erase_busy && tif.recovery_sel && tif.div_valid && tif.run_idle && !s_q.idle_prev) begin
            s_d.erase_busy = 1'b1;
            s_d.erase_done = 1'b0;
        end else if (s_q.erase_busy && FLASH_ERASE_DONE) begin
            s_d.erase_busy = 1'b0;
            s_d.erase_done = 1'b1;
            s_d.secure     = 1'b0;
        end
        s_d.div_out = s_d.erase_busy ? tif.div_val : s_d.clkdiv;

        // ahb-lite data phase
        if (s_q.dp_write) begin
            s_d.dp_write = 1'b0;
            case (s_q.dp_addr)
                REG_CONTROL: begin
                    s_d.sw_reset = HWDATA[CTL_SW_RESET];
                end
                REG_CLKDIV: begin
                    s_d.clkdiv = HWDATA[DIV_W-1:0];
                end
                REG_KEY: begin
                    if (s_q.key_allow && (HWDATA == BACKDOOR_KEY) && !s_d.erase_busy) begin
                        s_d.secure = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            s_d.div_out = s_d.erase_busy ? tif.div_val : s_d.clkdiv;
        end
        // ahb-lite address phase
        if (HSEL && HREADY && HTRANS[1]) begin
            s_d.dp_write = HWRITE && addr_ok;
            s_d.dp_addr  = HADDR[ADDR_W-1:0];
            s_d.rdata    = '0;
            if (!HWRITE && addr_ok && (HADDR[31:ADDR_W] == '0)) begin
                case (HADDR[ADDR_W-1:0])
                    REG_STATUS: s_d.rdata = status_word;
                    REG_CLKDIV: s_d.rdata = {{(32-DIV_W){1'b0}}, s_q.clkdiv};
                    default:    s_d.rdata = '0;
                endcase
            end
            if (HADDR[31:ADDR_W] != '0) begin
                s_d.dp_write = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s_q             <= '0;
            s_q.sync1       <= 6'h3F;
            s_q.sync2       <= 6'h3F;
            s_q.seq         <= SEQ_POR_EXT;
            s_q.in_reset    <= 1'b1;
            s_q.por_pending <= 1'b1;
            s_q.periph_hold <= 1'b1;
            s_q.core_hold   <= 1'b1;
            s_q.secure      <= 1'b1;
            s_q.clkdiv      <= CLKDIV_RESET;
            s_q.div_out     <= CLKDIV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign CLK_ENABLE              = s_q.clk_run;
    assign PERIPH_RESET            = s_q.periph_hold;
    assign CORE_RESET              = s_q.core_hold;
    assign DEBUG_PORT_EN           = !s_q.secure;
    assign DEBUG_READ_BLOCK        = s_q.secure;
    assign FLASH_ERASE_REQ         = s_q.erase_busy;
    assign FLASH_PRESCALE_BY_EIGHT = s_q.div_out[DIV_PRESCALE];
    assign FLASH_CLOCK_RATIO       = s_q.div_out[5:0];
    assign TDO                     = tif.tdo;
    assign TDO_OE_N                = !tif.tdo_drive;
    assign HREADYOUT               = 1'b1;
    assign HRESP                   = 1'b0;
    assign HRDATA                  = s_q.rdata;
endmodule // rssl_top
`default_nettype wire

// ---- core/rssl_pkg.sv ----
// package: constants and types of the reset sequencer and security lock
package rssl_pkg;
    // sequencing windows
    localparam int unsigned POR_EXT_DEFAULT = 2097152;
    localparam int unsigned WINDOW_CYCLES   = 32;
    localparam int unsigned CNT_W           = 22;
    // register byte offsets
    localparam logic [7:0] REG_CONTROL  = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CLKDIV   = 8'h08;
    localparam logic [7:0] REG_KEY      = 8'h0C;
    localparam int unsigned ADDR_W      = 8;
    // control fields
    localparam int unsigned CTL_SW_RESET = 0;
    // status fields
    localparam int unsigned ST_SEQ_LSB   = 0;
    localparam int unsigned ST_SECURE    = 4;
    localparam int unsigned ST_KEY_ALLOW = 5;
    localparam int unsigned ST_ERASE_BSY = 6;
    localparam int unsigned ST_ERASE_DON = 7;
    localparam int unsigned ST_DIV_VALID = 8;
    // flash divider layout
    localparam int unsigned DIV_W         = 7;
    localparam int unsigned DIV_PRESCALE  = 6;
    localparam logic [6:0]  CLKDIV_RESET  = 7'h00;
    // security byte decoding
    localparam logic [1:0]  SEC_UNSECURE_CODE = 2'h2;
    localparam logic [1:0]  KEY_ALLOW_CODE    = 2'h2;
    localparam int unsigned KEY_ALLOW_LSB     = 6;
    // jtag
    localparam int unsigned IR_W        = 4;
    localparam logic [3:0]  IR_IDCODE   = 4'h2;
    localparam logic [3:0]  IR_RECOVERY = 4'h8;
    localparam logic [3:0]  IR_BYPASS   = 4'hF;
    localparam logic [3:0]  IR_CAPTURE  = 4'h1;
    localparam int unsigned DR_W        = 32;
    // arbitrary neutral identification value
    localparam logic [31:0] IDCODE_VALUE = 32'h1234_5001;

    typedef enum logic [2:0] {
        SEQ_POR_EXT   = 3'h0,
        SEQ_CLK_START = 3'h1,
        SEQ_PERIPH    = 3'h2,
        SEQ_CORE      = 3'h3,
        SEQ_RUN       = 3'h4
    } rssl_seq_e;

    typedef enum logic [3:0] {
        TAP_RESET   = 4'h0, TAP_IDLE    = 4'h1, TAP_SEL_DR  = 4'h2, TAP_CAP_DR  = 4'h3,
        TAP_SH_DR   = 4'h4, TAP_EX1_DR  = 4'h5, TAP_PAU_DR  = 4'h6, TAP_EX2_DR  = 4'h7,
        TAP_UPD_DR  = 4'h8, TAP_SEL_IR  = 4'h9, TAP_CAP_IR  = 4'hA, TAP_SH_IR   = 4'hB,
        TAP_EX1_IR  = 4'hC, TAP_PAU_IR  = 4'hD, TAP_EX2_IR  = 4'hE, TAP_UPD_IR  = 4'hF
    } rssl_tap_e;
endpackage

// ---- core/rssl_tap_if.sv ----
// interface: synchronised jtag pins and test access port results
`timescale 1ns/1ps
`default_nettype none
interface rssl_tap_if;
    logic       tck_rise;
    logic       tms;
    logic       tdi;
    logic       trst;
    logic       tdo;
    logic       tdo_drive;
    logic       recovery_sel;
    logic       run_idle;
    logic       div_valid;
    logic [6:0] div_val;
    modport core (output tck_rise, tms, tdi, trst,
                  input  tdo, tdo_drive, recovery_sel, run_idle, div_valid, div_val);
    modport tap  (input  tck_rise, tms, tdi, trst,
                  output tdo, tdo_drive, recovery_sel, run_idle, div_valid, div_val);
endinterface
`default_nettype wire

// ---- core/rssl_tap.sv ----
// module: chip-level test access port with identification and recovery registers
`timescale 1ns/1ps
`default_nettype none
module rssl_tap (
    input  wire logic clk,
    input  wire logic reset,
    rssl_tap_if.tap   tif
);
    import rssl_pkg::*;

    typedef struct packed {
        rssl_tap_e         st;
        logic [IR_W-1:0]   ir_sh;
        logic [IR_W-1:0]   ir;
        logic [DR_W-1:0]   dr_sh;
        logic [DIV_W-1:0]  div;
        logic              div_valid;
        logic              tdo;
        logic              tdo_drive;
    } rssl_tap_s;

    rssl_tap_s s_q, s_d;

    function automatic rssl_tap_e tap_next(input rssl_tap_e st, input logic tms);
        case (st)
            TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            default:    tap_next = TAP_RESET;
        endcase
    endfunction

    always_comb begin
        s_d = s_q;
        if (tif.trst) begin
            s_d.st        = TAP_RESET;
            s_d.ir        = IR_IDCODE;
            s_d.div_valid = 1'b0;
            s_d.tdo_drive = 1'b0;
        end else if (tif.tck_rise) begin
            s_d.st = tap_next(s_q.st, tif.tms);
            case (s_q.st)
                TAP_RESET: begin
                    s_d.ir = IR_IDCODE;
                end
                TAP_CAP_IR: begin
                    s_d.ir_sh = IR_CAPTURE;
                end
                TAP_SH_IR: begin
                    s_d.ir_sh = {tif.tdi, s_q.ir_sh[IR_W-1:1]};
                end
                TAP_UPD_IR: begin
                    s_d.ir = s_q.ir_sh;
                end
                TAP_CAP_DR: begin
                    case (s_q.ir)
                        IR_IDCODE:   s_d.dr_sh = IDCODE_VALUE;
                        IR_RECOVERY: s_d.dr_sh = {{(DR_W-DIV_W){1'b0}}, s_q.div};
                        default:     s_d.dr_sh = '0;
                    endcase
                end
                TAP_SH_DR: begin
                    case (s_q.ir)
                        IR_IDCODE:   s_d.dr_sh = {tif.tdi, s_q.dr_sh[DR_W-1:1]};
                        IR_RECOVERY: s_d.dr_sh = {{(DR_W-DIV_W){1'b0}}, tif.tdi, s_q.dr_sh[DIV_W-1:1]};
                        default:     s_d.dr_sh = {{(DR_W-1){1'b0}}, tif.tdi};
                    endcase
                end
                TAP_UPD_DR: begin
                    if (s_q.ir == IR_RECOVERY) begin
                        s_d.div       = s_q.dr_sh[DIV_W-1:0];
                        s_d.div_valid = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            s_d.tdo_drive = (s_d.st == TAP_SH_DR) || (s_d.st == TAP_SH_IR);
        end
        s_d.tdo = (s_q.st == TAP_SH_IR) ? s_q.ir_sh[0] : s_q.dr_sh[0];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q           <= '0;
            s_q.st        <= TAP_RESET;
            s_q.ir        <= IR_IDCODE;
            s_q.div       <= CLKDIV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.tdo          = s_q.tdo;
    assign tif.tdo_drive    = s_q.tdo_drive;
    assign tif.recovery_sel = (s_q.ir == IR_RECOVERY);
    assign tif.run_idle     = (s_q.st == TAP_IDLE);
    assign tif.div_valid    = s_q.div_valid;
    assign tif.div_val      = s_q.div;
endmodule // rssl_tap
`default_nettype wire

// ---- testbench/rssl_top_sva.sv ----
// checker: assertions on the top ports
`timescale 1ns/1ps
`default_nettype none
module rssl_top_sva #(
    parameter int unsigned POR_EXT_CYCLES = 16
) (
    input wire logic       CLK,
    input wire logic       RESET,
    input wire logic       EXT_RESET_N,
    input wire logic       WDOG_RESET,
    input wire logic       FLASH_ERASE_DONE,
    input wire logic       CLK_ENABLE,
    input wire logic       PERIPH_RESET,
    input wire logic       CORE_RESET,
    input wire logic       DEBUG_PORT_EN,
    input wire logic       DEBUG_READ_BLOCK,
    input wire logic       FLASH_ERASE_REQ,
    input wire logic       FLASH_PRESCALE_BY_EIGHT,
    input wire logic [5:0] FLASH_CLOCK_RATIO
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    sequence s_clk_up; $rose(CLK_ENABLE); endsequence
    sequence s_periph_go; $fell(PERIPH_RESET); endsequence
    sequence s_core_go; $fell(CORE_RESET); endsequence
    a_periph_window: assert property (s_clk_up |-> ##32 s_periph_go)
        else $error("late periph release");
    a_core_window: assert property (s_periph_go |-> ##64 s_core_go)
        else $error("late core release");
    a_reset_hold: assert property (disable iff (1'b0) RESET |=> CORE_RESET && PERIPH_RESET && !CLK_ENABLE)
        else $error("reset outputs not held");
    a_wdog_reset: assert property (WDOG_RESET |-> ##[1:3] CORE_RESET)
        else $error("watchdog missed");
    a_pin_reset: assert property ($fell(EXT_RESET_N) |-> ##[1:4] (PERIPH_RESET && CORE_RESET))
        else $error("pin reset missed");
    a_debug_lock: assert property (DEBUG_PORT_EN != DEBUG_READ_BLOCK)
        else $error("debug lock mismatch");
    a_block_latch: assert property ($rose(DEBUG_READ_BLOCK) |-> PERIPH_RESET || $past(PERIPH_RESET))
        else $error("late read block");
    a_div_hold: assert property (FLASH_ERASE_REQ && $past(FLASH_ERASE_REQ) |->
        $stable({FLASH_PRESCALE_BY_EIGHT, FLASH_CLOCK_RATIO})) else $error("divider moved");
    a_erase_end: assert property (FLASH_ERASE_REQ && FLASH_ERASE_DONE |=> !FLASH_ERASE_REQ && !DEBUG_READ_BLOCK)
        else $error("erase end left secure");
endmodule // rssl_top_sva
bind rssl_top rssl_top_sva #(.POR_EXT_CYCLES(POR_EXT_CYCLES)) u_sva (
    .CLK, .RESET, .EXT_RESET_N, .WDOG_RESET, .FLASH_ERASE_DONE, .CLK_ENABLE, .PERIPH_RESET, .CORE_RESET,
    .DEBUG_PORT_EN, .DEBUG_READ_BLOCK, .FLASH_ERASE_REQ, .FLASH_PRESCALE_BY_EIGHT, .FLASH_CLOCK_RATIO
);
`default_nettype wire

// ---- testbench/rssl_jtag_host.sv ----
// partner: jtag host and reset pins
`timescale 1ns/1ps
`default_nettype none
module rssl_jtag_host (
    input  wire logic clk,
    output var logic  tck,
    output var logic  tms,
    output var logic  tdi,
    output var logic  trst_n,
    output var logic  ext_n,
    output var logic  por_n
);
    initial begin
        {tck, tdi} = 2'h0;
        {tms, trst_n, ext_n, por_n} = 4'hF;
    end
    task automatic step(input logic m, input logic d);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (5) @(posedge clk);
        tck <= 1'b1;
        repeat (5) @(posedge clk);
        tck <= 1'b0;
    endtask
    task automatic shift(input logic ir, input logic [6:0] v, input int bits);
        step(1'b1, 1'b0);
        if (ir)
            step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < bits; i++)
            step(i == bits - 1, v[i]);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    // low pulse: 0 power-on, 1 pin, 2 port reset
    task automatic pulse(input int w);
        @(posedge clk);
        por_n <= (w != 0);
        ext_n <= (w != 1);
        trst_n <= (w != 2);
        repeat (6) @(posedge clk);
        {por_n, ext_n, trst_n} <= 3'h7;
    endtask
endmodule // rssl_jtag_host
`default_nettype wire

// ---- testbench/rssl_top_test.sv ----
// testbench: reset, security, bus and recovery scenarios
`timescale 1ns/1ps
`default_nettype none
module rssl_top_test;
    import rssl_pkg::*;
    localparam int POR_EXT = 16;
    logic        clk, reset, wdog, done, hwrite, hsel;
    logic [2:0]  hsize;
    logic [7:0]  sec_lo, sec_hi;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, key, r;
    wire logic   clk_en, per_rst, core_rst, port_en, blk, erase, pre8, rdy, resp, tdo, tdo_oe_n;
    wire logic   tck, tms, tdi, trst_n, ext_n, por_n;
    wire logic [5:0]  ratio;
    wire logic [31:0] hrdata;
    int          fails = 0, tests_run = 0, n;
    rssl_top #(.POR_EXT_CYCLES(POR_EXT)) dut (
        .CLK(clk), .RESET(reset), .EXT_RESET_N(ext_n), .POR_N(por_n), .WDOG_RESET(wdog),
        .SEC_BYTE_LO(sec_lo), .SEC_BYTE_HI(sec_hi), .BACKDOOR_KEY(key), .FLASH_ERASE_DONE(done),
        .CLK_ENABLE(clk_en), .PERIPH_RESET(per_rst), .CORE_RESET(core_rst), .DEBUG_PORT_EN(port_en),
        .DEBUG_READ_BLOCK(blk), .FLASH_ERASE_REQ(erase), .FLASH_PRESCALE_BY_EIGHT(pre8),
        .FLASH_CLOCK_RATIO(ratio), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n), .TDO(tdo),
        .TDO_OE_N(tdo_oe_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(rdy), .HREADYOUT(rdy), .HRESP(resp), .HRDATA(hrdata)
    );
    rssl_jtag_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .ext_n(ext_n), .por_n(por_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bad(input string m);
        fails++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk_v(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) bad(m);
    endtask
    task automatic chk_n(input int got, lo, hi, input string m);
        tests_run++;
        if (got < lo || got > hi) bad(m);
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return clk_en;
            1: return per_rst;
            2: return core_rst;
            3: return erase;
            default: return blk;
        endcase
    endfunction
    task automatic wait_lvl(input int w, input logic v);
        n = 0;
        while (pick(w) !== v) begin
            @(posedge clk);
            n++;
            if (n > 400) begin
                bad("timeout");
                tally_and_finish();
            end
        end
    endtask
    task automatic edge_rdy;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) begin
                bad("bus timeout");
                tally_and_finish();
            end
        end while (rdy !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        edge_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        r = hrdata;
    endtask
    task automatic restart;
        ahb(1'b1, REG_CONTROL, 32'h1);
        wait_lvl(2, 1'b1);
        wait_lvl(2, 1'b0);
    endtask
    task automatic t_por;
        host.pulse(0);
        wait_lvl(0, 1'b1);
        chk_n(n, POR_EXT, POR_EXT + 6, "por extension");
        wait_lvl(1, 1'b0);
        chk_n(n, 32, 32, "clock window");
        wait_lvl(2, 1'b0);
        chk_n(n, 64, 64, "core window");
        chk_v(blk, 1'b1, "read block");
        chk_v(port_en, 1'b0, "debug port");
        ahb(1'b0, REG_STATUS, 32'h0);
        chk_v(r[4:0], 5'h14, "status");
        $display("test power-on done");
    endtask
    task automatic t_src(input int s);
        sec_lo <= (s == 0) ? 8'h02 : 8'h00;
        if (s == 0) host.pulse(1);
        if (s == 1) ahb(1'b1, REG_CONTROL, 32'h1);
        if (s == 2) begin
            @(posedge clk);
            wdog <= 1'b1;
            @(posedge clk);
            wdog <= 1'b0;
        end
        wait_lvl(0, 1'b0);
        wait_lvl(0, 1'b1);
        chk_n(n, 1, 8, "no extension");
        wait_lvl(2, 1'b0);
        chk_v(blk, s != 0, "security latch");
        $display("test source %0d done", s);
    endtask
    task automatic t_regs;
        ahb(1'b1, REG_CLKDIV, 32'h49);
        ahb(1'b0, REG_CLKDIV, 32'h0);
        chk_v(r, 32'h49, "readback");
        chk_v({pre8, ratio}, 7'h49, "div outputs");
        ahb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
        ahb(1'b0, REG_STATUS, 32'h0);
        chk_v(r[8:0], 9'h014, "read only");
        ahb(1'b0, 32'h10, 32'h0);
        chk_v({resp, r}, 33'h0, "unmapped read");
        ahb(1'b1, REG_KEY, key);
        repeat (3) @(posedge clk);
        chk_v(blk, 1'b1, "key refused");
        sec_hi <= 8'h80;
        restart();
        ahb(1'b0, REG_STATUS, 32'h0);
        chk_v(r[5:4], 2'h3, "key allowed");
        ahb(1'b1, REG_KEY, key);
        wait_lvl(4, 1'b0);
        chk_n(n, 0, 3, "key unlock");
        $display("test registers done");
    endtask
    task automatic t_recovery;
        sec_hi <= 8'h00;
        restart();
        host.step(1'b0, 1'b0);
        host.shift(1'b1, 7'h08, 4);
        host.shift(1'b0, 7'h49, 7);
        wait_lvl(3, 1'b1);
        chk_n(n, 0, 4, "erase start");
        chk_v({pre8, ratio}, 7'h49, "jtag divider");
        ahb(1'b0, REG_STATUS, 32'h0);
        chk_v(r[8:6], 3'h5, "erase busy");
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        wait_lvl(3, 1'b0);
        chk_v(blk, 1'b0, "erase unlock");
        ahb(1'b0, REG_STATUS, 32'h0);
        chk_v(r[7:4], 4'h8, "erase done");
        host.pulse(2);
        sec_lo <= 8'h02;
        host.pulse(1);
        wait_lvl(2, 1'b0);
        chk_v(port_en, 1'b1, "unsecured");
        hsize <= 3'h0;
        ahb(1'b0, REG_CLKDIV, 32'h0);
        chk_v(r, 32'h0, "byte read ignored");
        $display("test recovery done");
    endtask
    initial begin
        reset = 1'b1;
        {wdog, done, hwrite, htrans, haddr, hwdata} = '0;
        {hsel, hsize} = 4'hA;
        {sec_lo, sec_hi} = 16'h0000;
        key = 32'hA5C3_0F96;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        wait_lvl(2, 1'b0);
        t_por();
        for (int s = 0; s < 3; s++)
            t_src(s);
        t_regs();
        t_recovery();
        tally_and_finish();
    end
endmodule // rssl_top_test
`default_nettype wire
